//--- common/cswm_regs.vh
// register indices, field positions and reset values of the window mapper
`ifndef CSWM_REGS_VH
`define CSWM_REGS_VH
// register index = byte address / 4; window n word k = base + 4*n + k
`define CSWM_MW_BASE 8'h00
`define CSWM_IO_BASE 8'h18
`define CSWM_WIN_STRIDE 8'h04
`define CSWM_W_RANGE 2'h0
`define CSWM_W_XLATE 2'h1
`define CSWM_W_CTL 2'h2
`define CSWM_MISC1 8'h16
`define CSWM_MISC3 8'h25
`define CSWM_STATUS 8'h20
// index field of haddr
`define CSWM_IDX_HI 9
`define CSWM_IDX_LO 2
`define CSWM_HSIZE_WORD 3'h2
// memory window range word: start 11:0, end 27:16 (4-Kbyte blocks)
`define CSWM_MW_START_HI 11
`define CSWM_MW_START_LO 0
`define CSWM_MW_END_HI 27
`define CSWM_MW_END_LO 16
`define CSWM_MW_RANGE_MASK 32'h0fff_0fff
// memory window translate word: offset 13:0, upper page 31:24
`define CSWM_MW_OFF_HI 13
`define CSWM_MW_OFF_LO 0
`define CSWM_MW_UP_HI 31
`define CSWM_MW_UP_LO 24
`define CSWM_MW_XLATE_MASK 32'hff00_3fff
// host address fields
`define CSWM_PAGE_HI 31
`define CSWM_PAGE_LO 24
`define CSWM_BLK_HI 23
`define CSWM_BLK_LO 12
`define CSWM_IO_SPACE_HI 31
`define CSWM_IO_SPACE_LO 16
`define CSWM_BLK_ZERO 12'h000
// i/o window range word: start 15:0, end 31:16; translate offset 15:0
`define CSWM_IO_START_HI 15
`define CSWM_IO_START_LO 0
`define CSWM_IO_END_HI 31
`define CSWM_IO_END_LO 16
`define CSWM_IO_OFF_HI 15
`define CSWM_IO_OFF_LO 0
// control word bits
`define CSWM_EN_BIT 0
`define CSWM_TSET_BIT 1
`define CSWM_REG_BIT 2
`define CSWM_WP_BIT 3
`define CSWM_AUTO_BIT 2
`define CSWM_SZ16_BIT 3
`define CSWM_MM_EN_BIT 0
`define CSWM_MM_ARM_BIT 7
`define CSWM_ZV_STAT_BIT 8
// reset values
`define CSWM_CFG_RST 32'h0000_0000
`define CSWM_CTL_RST 4'h0
`define CSWM_MISC_RST 8'h00
`define CSWM_OFF_RST 16'h0000
`endif

//--- rtl/cswm_memwin.v
// one memory window: page, range compare and card address translation
`default_nettype none
`include "cswm_regs.vh"
module cswm_memwin (
   input wire [31:0] addr,
   input wire [31:0] range_w,
   input wire [31:0] xlate_w,
   input wire enable,
   output wire hit,
   output wire [25:0] card_addr
);
   wire [7:0] page;
   wire [7:0] upper;
   wire [11:0] blk;
   wire [11:0] start_blk;
   wire [11:0] end_blk;
   wire [13:0] offset;

   // field extraction
   assign page = addr[`CSWM_PAGE_HI:`CSWM_PAGE_LO];
   assign upper = xlate_w[`CSWM_MW_UP_HI:`CSWM_MW_UP_LO];
   assign blk = addr[`CSWM_BLK_HI:`CSWM_BLK_LO];
   assign start_blk = range_w[`CSWM_MW_START_HI:`CSWM_MW_START_LO];
   assign end_blk = range_w[`CSWM_MW_END_HI:`CSWM_MW_END_LO];
   assign offset = xlate_w[`CSWM_MW_OFF_HI:`CSWM_MW_OFF_LO];

   // enable, page match and inclusive 4-Kbyte range
   assign hit = enable & (page == upper) & // [RL2] [RL6] [RL17]
      (blk >= start_blk) & (blk <= end_blk); // [RL3] [RL4]

   // offset counts 4-Kbyte blocks; carries past bit 25 are dropped
   assign card_addr = addr[25:0] + {offset, `CSWM_BLK_ZERO}; // [RL5]
endmodule // cswm_memwin
`default_nettype wire

//--- rtl/cswm_mapper.v
// socket window mapper: ahb-lite registers, window decode, card address
// Operation
// [RL1] five memory windows per socket map host memory onto the card
// [RL2] each memory window has its own enable; disabled windows never claim
// [RL3] memory window start is 4-Kbyte aligned inside the selected page
// [RL4] 4-Kbyte aligned end; only accesses from start to end claimed
// [RL5] card address is host address plus the window offset
// [RL6] per-window upper address selects the 16-Mbyte host page
// [RL7] each window picks timing set zero or timing set one
// [RL8] per-window bit asserts the attribute select on card accesses
// [RL9] write-protected window drops writes, reads proceed
// [RL10] two i/o windows per socket, each with its own enable
// [RL11] i/o start and end at byte granularity within 64 Kbytes
// [RL12] automatic sizing takes i/o width from the card 16-bit signal
// [RL13] manual 8 or 16 bit i/o width overrides automatic sizing; here the size bit is used only when the auto bit is clear
// [RL14] software must never program overlapping windows
// [RL15] zoomed video only when multimedia enable and arm both set
// [RL16] zoomed video floats card address lines 25 to 4
// [RL17] hit needs page match and inclusive start-to-end range
//
// Design decision made here: the AHB-Lite slave port.
`default_nettype none
`include "cswm_regs.vh"
module cswm_mapper #(
   parameter NMW = 5,
   parameter NIO = 2
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire host_req,
   input wire host_io,
   input wire host_write,
   input wire [31:0] host_addr,
   input wire card_iois16_n,
   output reg claim,
   output reg card_req,
   output reg wp_drop,
   output reg [25:0] card_addr,
   output reg card_reg_n,
   output reg card_io,
   output reg card_write,
   output reg card_wide,
   output reg card_tset,
   output reg card_addr_hi_oe
);
   // bus slave state
   reg wr_pend;
   reg [7:0] wr_idx;
   reg rd_late;
   reg [7:0] rd_idx;
   reg [7:0] misc1;
   reg [7:0] misc3;
   reg [NMW+NIO-1:0] last_hit;
   wire accept;
   wire [7:0] addr_idx;
   wire [7:0] rsel_idx;
   wire zv_mode;
   reg [31:0] rdata;
   // per-window flattened results
   wire [NMW-1:0] mw_hit;
   wire [26*NMW-1:0] mw_caddr;
   wire [4*NMW-1:0] mw_ctl;
   wire [32*NMW-1:0] rb_mw;
   wire [NIO-1:0] io_hit;
   wire [26*NIO-1:0] io_caddr;
   wire [4*NIO-1:0] io_ctl;
   wire [32*NIO-1:0] rb_io;
   // selected window
   reg sel_hit;
   reg [25:0] sel_addr;
   reg sel_reg;
   reg sel_wp;
   reg sel_tset;
   reg sel_wide;
   reg [NMW+NIO-1:0] sel_mask;
   integer i;
   integer k;

   assign accept = hsel & htrans[1] & hready;
   assign addr_idx = haddr[`CSWM_IDX_HI:`CSWM_IDX_LO];
   // a read stalled behind a write reuses its captured index
   assign rsel_idx = rd_late ? rd_idx : addr_idx;
   assign zv_mode = misc1[`CSWM_MM_EN_BIT] & misc3[`CSWM_MM_ARM_BIT]; // [RL15]

   // memory windows: registers, readback and decoder per window
   genvar g;
   generate
      for (g = 0; g < NMW; g = g + 1) begin : g_mw // [RL1]
         // integer sum cut to the 8-bit register index on purpose
         localparam integer BASE_I = `CSWM_MW_BASE + `CSWM_WIN_STRIDE * g;
         localparam [7:0] BASE = BASE_I[7:0];
         reg [31:0] rng;
         reg [31:0] xl;
         reg [3:0] ctl;
         wire [31:0] sub_rd;
         // software writes land in the data phase
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               rng <= `CSWM_CFG_RST;
               xl <= `CSWM_CFG_RST;
               ctl <= `CSWM_CTL_RST;
            end else if (wr_pend && wr_idx[7:2] == BASE[7:2]) begin
               case (wr_idx[1:0])
                  `CSWM_W_RANGE: rng <= hwdata & `CSWM_MW_RANGE_MASK;
                  `CSWM_W_XLATE: xl <= hwdata & `CSWM_MW_XLATE_MASK;
                  `CSWM_W_CTL: ctl <= hwdata[3:0];
                  default: ctl <= ctl;
               endcase
            end
         end
         assign sub_rd = (rsel_idx[1:0] == `CSWM_W_RANGE) ? rng :
            (rsel_idx[1:0] == `CSWM_W_XLATE) ? xl :
            (rsel_idx[1:0] == `CSWM_W_CTL) ? {28'h0000000, ctl} :
            32'h0000_0000;
         assign rb_mw[g*32 +: 32] =
            (rsel_idx[7:2] == BASE[7:2]) ? sub_rd : 32'h0000_0000;
         assign mw_ctl[g*4 +: 4] = ctl;
         cswm_memwin u_win (
            .addr(host_addr),
            .range_w(rng),
            .xlate_w(xl),
            .enable(ctl[`CSWM_EN_BIT]),
            .hit(mw_hit[g]),
            .card_addr(mw_caddr[g*26 +: 26])
         );
      end
   endgenerate

   // i/o windows: byte-granular range inside the 64-Kbyte i/o space
   generate
      for (g = 0; g < NIO; g = g + 1) begin : g_io // [RL10]
         localparam integer BASE_I = `CSWM_IO_BASE + `CSWM_WIN_STRIDE * g;
         localparam [7:0] BASE = BASE_I[7:0];
         reg [31:0] rng;
         reg [15:0] off;
         reg [3:0] ctl;
         wire [15:0] port;
         wire [15:0] sum;
         wire [31:0] sub_rd;
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               rng <= `CSWM_CFG_RST;
               off <= `CSWM_OFF_RST;
               ctl <= `CSWM_CTL_RST;
            end else if (wr_pend && wr_idx[7:2] == BASE[7:2]) begin
               case (wr_idx[1:0])
                  `CSWM_W_RANGE: rng <= hwdata;
                  `CSWM_W_XLATE: off <= hwdata[`CSWM_IO_OFF_HI:0];
                  `CSWM_W_CTL: ctl <= hwdata[3:0];
                  default: ctl <= ctl;
               endcase
            end
         end
         assign port = host_addr[15:0];
         // upper host bits must be clear: i/o space is 64 Kbytes
         assign io_hit[g] = ctl[`CSWM_EN_BIT] & // [RL10]
            (host_addr[`CSWM_IO_SPACE_HI:`CSWM_IO_SPACE_LO] == 16'h0000) &
            (port >= rng[`CSWM_IO_START_HI:`CSWM_IO_START_LO]) & // [RL11]
            (port <= rng[`CSWM_IO_END_HI:`CSWM_IO_END_LO]);
         assign sum = port + off; // [RL5]
         assign io_caddr[g*26 +: 26] = {10'h000, sum};
         assign io_ctl[g*4 +: 4] = ctl;
         assign sub_rd = (rsel_idx[1:0] == `CSWM_W_RANGE) ? rng :
            (rsel_idx[1:0] == `CSWM_W_XLATE) ? {16'h0000, off} :
            (rsel_idx[1:0] == `CSWM_W_CTL) ? {28'h0000000, ctl} :
            32'h0000_0000;
         assign rb_io[g*32 +: 32] =
            (rsel_idx[7:2] == BASE[7:2]) ? sub_rd : 32'h0000_0000;
      end
   endgenerate

   // pick the hitting window; lowest index wins, since overlap is a
   // software fault and must not leave the card signals undefined
   always @* begin
      sel_hit = 1'b0;
      sel_addr = 26'h0000000;
      sel_reg = 1'b0;
      sel_wp = 1'b0;
      sel_tset = 1'b0;
      sel_wide = 1'b0;
      sel_mask = {(NMW+NIO){1'b0}};
      if (host_io) begin
         for (i = NIO - 1; i >= 0; i = i - 1) begin
            if (io_hit[i]) begin
               sel_hit = 1'b1;
               sel_addr = io_caddr[i*26 +: 26];
               sel_tset = io_ctl[i*4 + `CSWM_TSET_BIT]; // [RL7]
               // manual size unless auto is set
               if (io_ctl[i*4 + `CSWM_AUTO_BIT]) begin
                  sel_wide = ~card_iois16_n; // [RL12]
               end else begin
                  sel_wide = io_ctl[i*4 + `CSWM_SZ16_BIT]; // [RL13]
               end
            end
         end
         sel_mask[NMW+NIO-1:NMW] = io_hit;
      end else begin
         for (i = NMW - 1; i >= 0; i = i - 1) begin
            if (mw_hit[i]) begin
               sel_hit = 1'b1;
               sel_addr = mw_caddr[i*26 +: 26];
               sel_reg = mw_ctl[i*4 + `CSWM_REG_BIT]; // [RL8]
               sel_wp = mw_ctl[i*4 + `CSWM_WP_BIT]; // [RL9]
               sel_tset = mw_ctl[i*4 + `CSWM_TSET_BIT]; // [RL7]
               sel_wide = 1'b1;
            end
         end
         sel_mask[NMW-1:0] = mw_hit;
      end
   end

   // readback mux; unmapped indices read zero
   always @* begin
      rdata = 32'h0000_0000;
      for (k = 0; k < NMW; k = k + 1) begin
         rdata = rdata | rb_mw[k*32 +: 32];
      end
      for (k = 0; k < NIO; k = k + 1) begin
         rdata = rdata | rb_io[k*32 +: 32];
      end
      if (rsel_idx == `CSWM_MISC1) begin
         rdata = {24'h000000, misc1};
      end
      if (rsel_idx == `CSWM_MISC3) begin
         rdata = {24'h000000, misc3};
      end
      if (rsel_idx == `CSWM_STATUS) begin
         rdata = 32'h0000_0000;
         rdata[NMW+NIO-1:0] = last_hit;
         rdata[`CSWM_ZV_STAT_BIT] = zv_mode;
      end
   end

   // ahb-lite slave: writes zero wait, reads zero wait except one wait
   // state right behind a write, so readback never shows stale data
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
         rd_late <= 1'b0;
         rd_idx <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         wr_pend <= accept & hwrite & (hsize == `CSWM_HSIZE_WORD);
         if (accept) begin
            wr_idx <= addr_idx;
         end
         if (rd_late) begin
            hrdata <= rdata;
            hreadyout <= 1'b1;
            rd_late <= 1'b0;
         end else if (accept && !hwrite && wr_pend) begin
            rd_idx <= addr_idx;
            rd_late <= 1'b1;
            hreadyout <= 1'b0;
         end else if (accept && !hwrite) begin
            hrdata <= rdata;
         end
      end
   end

   // misc control registers for the multimedia path
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         misc1 <= `CSWM_MISC_RST;
         misc3 <= `CSWM_MISC_RST;
      end else if (wr_pend) begin
         if (wr_idx == `CSWM_MISC1) begin
            misc1 <= hwdata[7:0];
         end
         if (wr_idx == `CSWM_MISC3) begin
            misc3 <= hwdata[7:0];
         end
      end
   end

   // card-side outputs, one cycle after the host request
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         claim <= 1'b0;
         card_req <= 1'b0;
         wp_drop <= 1'b0;
         card_addr <= 26'h0000000;
         card_reg_n <= 1'b1;
         card_io <= 1'b0;
         card_write <= 1'b0;
         card_wide <= 1'b0;
         card_tset <= 1'b0;
         card_addr_hi_oe <= 1'b1;
         last_hit <= {(NMW+NIO){1'b0}};
      end else begin
         claim <= host_req & sel_hit; // [RL2] [RL17]
         // protected writes are claimed but start no card cycle
         card_req <= host_req & sel_hit & ~(host_write & sel_wp); // [RL9]
         wp_drop <= host_req & sel_hit & host_write & sel_wp; // [RL9]
         // floating a[25:4] hands the bus to the zoomed video sink
         card_addr_hi_oe <= ~zv_mode; // [RL16]
         if (host_req) begin
            last_hit <= sel_mask;
         end
         if (host_req && sel_hit) begin
            card_addr <= sel_addr; // [RL5]
            card_reg_n <= ~sel_reg; // [RL8]
            card_io <= host_io;
            card_write <= host_write;
            card_wide <= sel_wide; // [RL12] [RL13]
            card_tset <= sel_tset; // [RL7]
         end
      end
   end
endmodule // cswm_mapper
`default_nettype wire

//--- dv/cswm_mapper_sva.sv
// concurrent checks on the socket window mapper ports
`default_nettype none
module cswm_mapper_sva #(
   parameter NMW = 5,
   parameter NIO = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic host_req,
   input wire logic host_io,
   input wire logic host_write,
   input wire logic claim,
   input wire logic card_req,
   input wire logic wp_drop,
   input wire logic [25:0] card_addr,
   input wire logic card_reg_n,
   input wire logic card_io,
   input wire logic card_write,
   input wire logic card_wide,
   input wire logic card_addr_hi_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wr_ap;
   // a register write address phase accepted by the slave
   assign wr_ap = hsel & htrans[1] & hwrite & hready;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   req_claim_a: assert property (card_req |-> claim)
      else $error("card cycle started without a claim");
   wp_only_a: assert property (wp_drop |-> claim && !card_req
      && card_write && !card_io) else $error("bad dropped write");
   no_req_a: assert property (!host_req |=> !claim && !card_req)
      else $error("claim with no host access");
   addr_hold_a: assert property (!claim |-> $stable(card_addr))
      else $error("card address moved without a claim");
   regn_hold_a: assert property (!claim |-> $stable(card_reg_n))
      else $error("attribute select moved without a claim");
   copy_kind_a: assert property (host_req ##1 claim |->
      card_io == $past(host_io) && card_write == $past(host_write))
      else $error("access kind not copied");
   mem_wide_a: assert property (claim && !card_io |-> card_wide)
      else $error("memory access not wide");
   // the enable only moves after a register write has landed
   zv_oe_a: assert property ($changed(card_addr_hi_oe) |->
      $past(wr_ap, 1) || $past(wr_ap, 2) || $past(wr_ap, 3))
      else $error("address enable moved without a write");
   one_wait_a: assert property (!hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   okay_resp_a: assert property (!hresp)
      else $error("slave answered with an error response");
   cover property (wp_drop);
   cover property (claim && card_io && card_wide);
   cover property (!card_addr_hi_oe);
endmodule // cswm_mapper_sva
bind cswm_mapper cswm_mapper_sva #(.NMW(NMW), .NIO(NIO))
   cswm_mapper_sva_inst (.*);
`default_nettype wire

//--- dv/cswm_card_model.sv
// behavioural pc card: 16-bit indication and count of card writes
`default_nettype none
module cswm_card_model (
   input wire logic hclk,
   input wire logic card_req,
   input wire logic card_write,
   input wire logic io16_cap,
   output logic card_iois16_n,
   output var int n_wr
);
   timeunit 1ns;
   timeprecision 1ns;
   // a wide i/o port pulls its size line low
   assign card_iois16_n = !io16_cap;
   // dropped writes must never reach the card, so count what arrives
   initial n_wr = 0;
   always @(posedge hclk) begin
      if (card_req && card_write) begin
         n_wr <= n_wr + 1;
      end
   end
endmodule // cswm_card_model
`default_nettype wire

//--- dv/cswm_mapper_tb_top.sv
// self-checking bench for the socket window mapper
`default_nettype none
module cswm_mapper_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hresp;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, host_addr = 0;
   logic hreadyout, host_req = 0, host_io = 0, host_write = 0;
   logic io16_cap = 0, card_iois16_n, claim, card_req, wp_drop, card_io;
   logic [25:0] card_addr;
   logic card_reg_n, card_write, card_wide, card_tset, card_addr_hi_oe;
   int n_wr, n_mismatch = 0, total_checks = 0;
   assign hready = hreadyout;
   always #50 hclk = ~hclk;
   cswm_mapper cswm_mapper_inst (.*);
   cswm_card_model cswm_card_model_inst (.*);
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // bounded so a stuck slave ends the run instead of hanging it
   task automatic wait_rdy();
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 40);
      if (i >= 40) begin
         n_mismatch++;
         $display("CHECK FAILED %0t bus timeout", $time);
         end_sim();
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wait_rdy();
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   // one host access; outputs are looked at in the answer cycle
   task automatic host(input logic io, w, input logic [31:0] a);
      @(posedge hclk);
      host_req <= 1;
      host_io <= io;
      host_write <= w;
      host_addr <= a;
      @(posedge hclk);
      host_req <= 0;
      @(negedge hclk);
   endtask
   function automatic logic [31:0] outs();
      return {claim, card_req, card_tset, card_reg_n, card_wide, card_io,
         card_addr};
   endfunction
   task automatic t_regs();
      ahb(0, 32'h08, 0);
      chk(rd, 32'h0);
      ahb(1, 32'h00, 32'hffff_ffff);
      ahb(0, 32'h00, 0);
      chk(rd, 32'h0fff_0fff);
      // a byte-sized write must be ignored by the slave
      hsize <= 3'h0;
      ahb(1, 32'h00, 32'h0);
      hsize <= 3'h2;
      ahb(0, 32'h00, 0);
      chk(rd, 32'h0fff_0fff);
      ahb(1, 32'hfc, 32'h1234_5678);
      ahb(0, 32'hfc, 0);
      chk(rd, 32'h0);
   endtask
   // each window on its own page, so none overlaps another
   task automatic t_mem();
      logic [11:0] s;
      logic [7:0] p;
      logic [13:0] o;
      logic [31:0] a;
      for (int n = 0; n < 5; n++) begin
         s = 12'(16 * (n + 1));
         p = 8'h40 + n[7:0];
         o = 14'h100 + n[13:0];
         ahb(1, 32'(16 * n), {4'h0, s + 12'h001, 4'h0, s});
         ahb(1, 32'(16 * n + 4), {p, 10'h0, o});
         ahb(1, 32'(16 * n + 8), {29'h0, n[1:0], 1'b1});
         a = {p, s, 12'h123};
         host(0, 0, a);
         chk(outs(), {2'b11, n[0], !n[1], 2'b10, a[25:0] + {o, 12'h0}});
         a = {p, s + 12'h001, 12'hffc};
         host(0, 1, a);
         chk(outs(), {2'b11, n[0], !n[1], 2'b10, a[25:0] + {o, 12'h0}});
         host(0, 0, {p, s + 12'h002, 12'h000});
         chk(claim, 0);
         host(0, 0, {p + 8'h10, s, 12'h000});
         chk(claim, 0);
      end
   endtask
   task automatic t_wp();
      int w0;
      ahb(1, 32'h08, 32'h9);
      w0 = n_wr;
      host(0, 1, 32'h4001_0000);
      chk({claim, card_req, wp_drop}, 3'b101);
      host(0, 0, 32'h4001_0000);
      chk({claim, card_req, wp_drop}, 3'b110);
      chk(n_wr, w0);
      ahb(0, 32'h80, 0);
      chk(rd, 32'h0000_0001);
      ahb(1, 32'h08, 32'h0);
      host(0, 0, 32'h4001_0000);
      chk(claim, 0);
   endtask
   // auto modes: card decides; manual modes: card says the opposite
   task automatic t_io();
      logic [15:0] s;
      logic [31:0] a;
      for (int n = 0; n < 2; n++) begin
         s = 16'h03f8 + 16'(32 * n);
         ahb(1, 32'(96 + 16 * n), {s + 16'h0007, s});
         ahb(1, 32'(100 + 16 * n), 32'h0000_1000);
         for (int m = 0; m < 4; m++) begin
            ahb(1, 32'(104 + 16 * n), {28'h0, m[0] ^ m[1], m[1:0] & 2'b10
               | {1'b0, n[0]}, 1'b1});
            io16_cap <= !(m[0] ^ m[1]);
            a = {16'h0, s + 16'h0007};
            host(1, 0, a);
            chk(outs(), {2'b11, n[0], 1'b1, m[0], 1'b1,
               10'h0, a[15:0] + 16'h1000});
         end
         host(1, 0, {16'h0, s + 16'h0008});
         chk(claim, 0);
         host(1, 0, {16'h0001, s});
         chk(claim, 0);
      end
   endtask
   task automatic t_zv();
      ahb(1, 32'h58, 32'h01);
      repeat (3) @(posedge hclk);
      chk(card_addr_hi_oe, 1);
      ahb(1, 32'h94, 32'h80);
      repeat (3) @(posedge hclk);
      chk(card_addr_hi_oe, 0);
      ahb(0, 32'h80, 0);
      chk(rd, 32'h0000_0100);
      ahb(1, 32'h58, 32'h00);
      repeat (3) @(posedge hclk);
      chk(card_addr_hi_oe, 1);
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1;
      t_regs();
      t_mem();
      t_wp();
      t_io();
      t_zv();
      end_sim();
   end
endmodule // cswm_mapper_tb_top
`default_nettype wire
